// file: rtl/spf_link_rx.sv
// Receive side on the serial clock: shift register and clock count.
// Assumes the host holds select and data steady around sclk edges.
`timescale 1ns/10ps

module spf_link_rx
  import spf_pkg::*;
(
  // Link clock and reset
  input  wire logic        sclk,
  input  wire logic        rst,
  // Pins
  input  wire logic        select_low_in,
  input  wire logic        serial_in,
  // Results, stable while deselected
  output logic [31:0]      rx_word,
  output logic [7:0]       rx_count
);

  logic [31:0] next_rx_word;
  logic [7:0]  next_rx_count;

  // Shift and count only while selected; count clears only on reset, reader takes deltas
  always_comb begin
    next_rx_word  = rx_word;
    next_rx_count = rx_count;
    if (select_low_in != SPF_DESELECTED) begin
      next_rx_word  = {serial_in, rx_word[31:1]};
      next_rx_count = rx_count + 8'h01;
    end
  end

  // Registers on the falling serial clock edge
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      rx_word  <= SPF_WORD_RST;
      rx_count <= SPF_CNT_RST;
    end else begin
      rx_word  <= next_rx_word;
      rx_count <= next_rx_count;
    end
  end

endmodule : spf_link_rx

// file: rtl/spf_pkg.sv
// Shared types and constants of the serial frame port.
// Assumes one system clock and a serial clock made by the host.

package spf_pkg;

  // ----------------------------------------------------------------
  // Frame geometry
  // ----------------------------------------------------------------
  localparam int         SPF_FRAME_BITS = 32;
  localparam int         SPF_CNT_W      = 8;
  localparam logic [7:0] SPF_CNT_FULL   = 8'h20;  // 32 clocks
  localparam logic [7:0] SPF_CNT_NONE   = 8'h00;  // Error probe only
  localparam logic [7:0] SPF_CNT_RST    = 8'h00;
  localparam logic [31:0] SPF_WORD_RST  = 32'h0000_0000;
  localparam logic       SPF_DESELECTED = 1'b1;

  // ----------------------------------------------------------------
  // Device operating modes (codes chosen freely)
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SPF_MODE_INIT     = 3'h0,
    SPF_MODE_NORMAL   = 3'h1,
    SPF_MODE_STOP     = 3'h2,
    SPF_MODE_SLEEP    = 3'h3,
    SPF_MODE_RESTART  = 3'h4,
    SPF_MODE_FAILSAFE = 3'h5
  } spf_mode_t;

  // Received word, first bit on the line is bit 0
  typedef struct packed {
    logic [7:0]  upper;  // Bits 31..24
    logic [15:0] data;   // Bits 23..8
    logic        rw;     // Bit 7
    logic [6:0]  addr;   // Bits 6..0
  } spf_cmd_t;

  // Response sources supplied by the device core
  typedef struct packed {
    logic [7:0]  status;  // Bits 31..24
    logic [15:0] rdata;   // Bits 23..8
    logic [6:0]  info;    // Bits 7..1
  } spf_resp_src_t;

  // Port runs only in init, normal and stop
  function automatic logic spf_port_on(input spf_mode_t m);
    spf_port_on = (m == SPF_MODE_INIT) || (m == SPF_MODE_NORMAL) ||
                  (m == SPF_MODE_STOP);
  endfunction : spf_port_on

endpackage : spf_pkg

// file: rtl/spf_port.sv
// Serial frame port, device side: 32-bit full duplex slave.
// Assumes mode and response data come from logic on mclk, and that
// sclk, select_low_in and serial_in come from the host.
//
// Behaviour
// - Frames are accepted only in init, normal or stop mode.
// - In sleep, restart and fail-safe the port neither decodes nor drives.
// - Each frame swaps one 32-bit word each way on a shared bus.
// - A falling select marks the start of a new frame.
// - The received word is acted on only after select returns high.
// - When select returns high the serial output is released.
// - Input data is sampled on each falling serial clock edge.
// - The next output bit is presented after each rising clock edge.
// - Input bits are never passed through to the output.
// - A count other than 0 or 32 drops the word and flags the next reply.
// - Serial clock high at either select edge is a frame error.
// - Bits 6..0 are the address, bit 7 the access kind.
// - Bits 23..8 carry the sixteen data bits.
`timescale 1ns/10ps

module spf_port
  import spf_pkg::*;
(
  // System clock and reset
  input  wire logic          mclk,
  input  wire logic          rst,
  // Link pins
  input  wire logic          sclk,
  input  wire logic          select_low_in,
  input  wire logic          serial_in,
  output logic               serial_out,
  output logic               serial_out_oe,
  // Device core side
  input  wire spf_mode_t     mode,
  input  wire spf_resp_src_t resp_src,
  output logic               cmd_valid,
  output spf_cmd_t           cmd,
  output logic               frame_err
);

  // ----------------------------------------------------------------
  // Link domain receiver
  // ----------------------------------------------------------------
  logic [31:0] link_word;
  logic [7:0]  link_count;

  spf_link_rx u_rx (
    .sclk          (sclk),
    .rst           (rst),
    .select_low_in (select_low_in),
    .serial_in     (serial_in),
    .rx_word       (link_word),
    .rx_count      (link_count)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pin_raw;
  logic [1:0] pin_sync;

  assign pin_raw = {sclk, select_low_in};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      spf_sync2 u_sync (
        .clk (mclk),
        .rst (rst),
        .d   (pin_raw[gi]),
        .q   (pin_sync[gi])
      );
    end
  endgenerate

  logic sel_s;
  logic sclk_s;
  logic sel_d;
  logic sclk_d;
  logic sel_fall;
  logic sel_rise;
  logic sclk_rise;
  logic port_on;

  assign sel_s     = pin_sync[0];
  assign sclk_s    = pin_sync[1];
  assign sel_fall  = sel_d & ~sel_s;
  assign sel_rise  = ~sel_d & sel_s;
  assign sclk_rise = sclk_s & ~sclk_d;
  assign port_on   = spf_port_on(mode);

  // Edge history flops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sel_d  <= ~SPF_DESELECTED;  // Synchroniser reset level, no false falling edge
      sclk_d <= 1'b0;
    end else begin
      sel_d  <= sel_s;
      sclk_d <= sclk_s;
    end
  end

  // ----------------------------------------------------------------
  // Frame state machine
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_OFF   = 4'h1,
    ST_IDLE  = 4'h2,
    ST_FRAME = 4'h4,
    ST_CHECK = 4'h8
  } spf_state_t;

  spf_state_t  state;
  spf_state_t  next_state;
  logic [31:0] tx_shift;
  logic [31:0] next_tx_shift;
  logic        next_serial_out;
  logic        next_serial_out_oe;
  logic        err_pend;
  logic        next_err_pend;
  logic        edge_bad;
  logic        next_edge_bad;
  logic [7:0]  cnt_base;
  logic [7:0]  next_cnt_base;
  logic [7:0]  delta;
  logic        next_cmd_valid;
  spf_cmd_t    next_cmd;
  logic        next_frame_err;
  logic        err_set;
  logic        err_take;
  logic        err_due;
  logic        next_err_due;

  // Link clocks seen since the frame began; data stable while deselected
  assign delta = link_count - cnt_base;

  // Next values of the frame logic
  always_comb begin
    next_state         = state;
    next_tx_shift      = tx_shift;
    next_serial_out    = serial_out;
    next_serial_out_oe = serial_out_oe;
    next_edge_bad      = edge_bad;
    next_cnt_base      = cnt_base;
    next_cmd_valid     = 1'b0;
    next_cmd           = cmd;
    next_frame_err     = 1'b0;
    err_set            = 1'b0;
    err_take           = 1'b0;
    case (state)
      ST_OFF: begin
        next_serial_out_oe = 1'b0;
        next_serial_out    = 1'b0;
        next_cnt_base      = link_count;
        if (port_on && sel_s == SPF_DESELECTED) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        next_cnt_base = link_count;
        if (!port_on) begin
          next_state = ST_OFF;
        end else if (sel_fall) begin
          next_tx_shift      = {resp_src, err_pend};
          next_serial_out    = err_pend;
          next_serial_out_oe = 1'b1;
          next_edge_bad      = sclk_s;
          err_take           = 1'b1;
          next_state         = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (!port_on) begin
          next_serial_out_oe = 1'b0;
          err_set            = 1'b1;
          next_state         = ST_OFF;
        end else if (sel_rise) begin
          next_serial_out_oe = 1'b0;
          next_edge_bad      = edge_bad | sclk_s;
          next_state         = ST_CHECK;
        end else if (sclk_rise) begin
          next_tx_shift   = {1'b0, tx_shift[31:1]};
          next_serial_out = tx_shift[1];
        end
      end
      ST_CHECK: begin
        next_cnt_base = link_count;
        next_state    = port_on ? ST_IDLE : ST_OFF;
        if (port_on) begin
          // bad count or edge drops word
          if (edge_bad || (delta != SPF_CNT_FULL &&
                           delta != SPF_CNT_NONE)) begin
            err_set        = 1'b1;
            next_frame_err = 1'b1;
          end else if (delta == SPF_CNT_FULL) begin
            next_cmd_valid = 1'b1;
            next_cmd       = spf_cmd_t'(link_word);
          end
        end
      end
      default: begin
        next_state         = ST_OFF;
        next_serial_out_oe = 1'b0;
      end
    endcase
    // flag set wins over its consumption
    next_err_pend = (err_pend & ~err_take) | err_set;
    // Check helper: a rejected frame is owed until the next reply starts
    next_err_due  = (err_due & ~(state == ST_IDLE && port_on && sel_fall)) |
                    frame_err;
  end

  // Frame registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state         <= ST_OFF;
      tx_shift      <= SPF_WORD_RST;
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
      err_pend      <= 1'b0;
      edge_bad      <= 1'b0;
      cnt_base      <= SPF_CNT_RST;
      cmd_valid     <= 1'b0;
      cmd           <= spf_cmd_t'(SPF_WORD_RST);
      frame_err     <= 1'b0;
      err_due       <= 1'b0;
    end else begin
      state         <= next_state;
      tx_shift      <= next_tx_shift;
      serial_out    <= next_serial_out;
      serial_out_oe <= next_serial_out_oe;
      err_pend      <= next_err_pend;
      edge_bad      <= next_edge_bad;
      cnt_base      <= next_cnt_base;
      cmd_valid     <= next_cmd_valid;
      cmd           <= next_cmd;
      frame_err     <= next_frame_err;
      err_due       <= next_err_due;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_start;
    state == ST_IDLE && port_on && sel_fall;
  endsequence

  sequence s_end;
    state == ST_FRAME && port_on && sel_rise;
  endsequence

  property p_mode_gate;
    @(posedge mclk) disable iff (rst)
    cmd_valid |-> $past(port_on);
  endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("command issued in a disabled mode");

  property p_off_quiet;
    @(posedge mclk) disable iff (rst)
    !port_on |=> !serial_out_oe ##1 !cmd_valid;
  endproperty
  a_off_quiet: assert property (p_off_quiet)
    else $error("port active while switched off");

  property p_full_word;
    @(posedge mclk) disable iff (rst)
    cmd_valid |-> $past(delta) == SPF_CNT_FULL;
  endproperty
  a_full_word: assert property (p_full_word)
    else $error("command from a frame not 32 clocks long");

  property p_start_load;
    @(posedge mclk) disable iff (rst)
    s_start |=> serial_out_oe && serial_out == $past(err_pend);
  endproperty
  a_start_load: assert property (p_start_load)
    else $error("frame start did not drive the error bit");

  property p_act_after;
    @(posedge mclk) disable iff (rst)
    cmd_valid |-> $past(state) == ST_CHECK && sel_d;
  endproperty
  a_act_after: assert property (p_act_after)
    else $error("command issued while still selected");

  property p_release;
    @(posedge mclk) disable iff (rst)
    s_end |=> !serial_out_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("output still driven after deselect");

  property p_shift_out;
    @(posedge mclk) disable iff (rst)
    (state == ST_FRAME && port_on && !sel_rise && sclk_rise)
      |=> serial_out == $past(tx_shift[1]);
  endproperty
  a_shift_out: assert property (p_shift_out)
    else $error("output did not advance after rising clock");

  property p_bad_count;
    @(posedge mclk) disable iff (rst)
    (state == ST_CHECK && port_on && delta != SPF_CNT_FULL &&
     delta != SPF_CNT_NONE) |=> err_pend && frame_err && !cmd_valid;
  endproperty
  a_bad_count: assert property (p_bad_count)
    else $error("bad clock count not flagged");

  property p_edge_high;
    @(posedge mclk) disable iff (rst)
    (s_end and sclk_s) |=> ##1 !cmd_valid && err_pend;
  endproperty
  a_edge_high: assert property (p_edge_high)
    else $error("clock high at deselect not flagged");

  property p_err_next;
    @(posedge mclk) disable iff (rst)
    s_start ##0 err_due |=> serial_out;
  endproperty
  a_err_next: assert property (p_err_next)
    else $error("error not shown at next reply start");

endmodule : spf_port

// file: rtl/spf_sync2.sv
// Two-stage level synchroniser into the system clock.
// Assumes the input is asynchronous to clk.
`timescale 1ns/10ps

module spf_sync2 (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Level in and out
  input  wire logic d,
  output logic      q
);

  logic meta;
  logic next_meta;
  logic next_q;

  // Next values
  always_comb begin
    next_meta = d;
    next_q    = meta;
  end

  // Two flops, the first read only by the second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end

endmodule : spf_sync2

// file: testbench/spf_host.sv
// Host model: serial bus master that frames, clocks and samples.
// Assumes the bench calls xfer and that oe qualifies serial_out.
`timescale 1ns/10ps

module spf_host (
  // Observed pins
  input  wire logic mclk,
  input  wire logic serial_out,
  input  wire logic serial_out_oe,
  // Driven pins
  output logic      sclk,
  output logic      select_low_in,
  output logic      serial_in
);

  // Released output shows the inverse of its last level
  logic out_line;
  assign out_line = serial_out_oe ? serial_out : ~serial_out;

  // ----------------------------------------------------------------
  // Idle pins
  // ----------------------------------------------------------------
  // Link clock stands low between frames
  initial begin
    sclk          = 1'b0;
    select_low_in = 1'b1;
    serial_in     = 1'b0;
  end

  // ----------------------------------------------------------------
  // One frame of n clocks, optional clock high at select fall
  // ----------------------------------------------------------------
  task automatic xfer(input int n, input logic [31:0] word,
                      input logic [1:0] hi, output logic [31:0] reply,
                      output bit oe_seen);
    reply   = 32'h0000_0000;
    oe_seen = 1'b0;
    @(negedge mclk);
    // optional clock high across the select fall
    sclk = hi[0];
    #40;
    select_low_in = 1'b0;
    #43;
    sclk = 1'b0;
    #40;
    reply[0] = out_line;
    oe_seen  = serial_out_oe;
    for (int i = 0; i < n; i++) begin
      if (i < 32) begin
        reply[i] = out_line;
        oe_seen  = oe_seen | serial_out_oe;
      end
      // host clock, data moves after the rise
      sclk      = 1'b1;
      serial_in = (i < 32) ? word[i] : 1'b0;
      #80;
      sclk = 1'b0;
      #80;
    end
    // optional clock high across the select rise
    sclk = hi[1];
    #40;
    select_low_in = 1'b1;
    // Released data line does not keep its last level
    serial_in = ~serial_in;
    #40;
    sclk = 1'b0;
    #100;
  endtask : xfer

endmodule : spf_host

// file: testbench/spf_port_bench.sv
// Bench for the serial frame port: host model plus scenario tasks.
// Assumes spf_pkg and the port design are compiled first.
`timescale 1ns/10ps

module spf_port_bench;
  import spf_pkg::*;

  logic          mclk;
  logic          rst;
  logic          sclk;
  logic          select_low_in;
  logic          serial_in;
  logic          serial_out;
  logic          serial_out_oe;
  spf_mode_t     mode;
  spf_resp_src_t resp_src;
  logic          cmd_valid;
  spf_cmd_t      cmd;
  logic          frame_err;
  logic [31:0]   reply;
  bit            oe_seen;
  int            error_cnt;
  int            check_count;
  int            valid_seen;
  int            err_seen;

  // ----------------------------------------------------------------
  // Design and host
  // ----------------------------------------------------------------
  spf_port dut (.mclk(mclk), .rst(rst), .sclk(sclk),
    .select_low_in(select_low_in), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .mode(mode), .resp_src(resp_src), .cmd_valid(cmd_valid),
    .cmd(cmd), .frame_err(frame_err));

  spf_host host (.mclk(mclk), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .sclk(sclk),
    .select_low_in(select_low_in), .serial_in(serial_in));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Count one compare, report a mismatch
  task automatic chk(input bit ok, input string msg);
    check_count++;
    if (!ok) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic close_out;
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  // Count result pulses; a word must never appear mid-frame
  always @(negedge mclk) begin
    if (cmd_valid === 1'b1) valid_seen++;
    if (frame_err === 1'b1) err_seen++;
    if (cmd_valid === 1'b1 && select_low_in === 1'b0)
      chk(1'b0, "word taken while selected");
  end

  // Frame, then let the result pulses land
  task automatic run(input int n, input logic [31:0] w,
                     input logic [1:0] hi, output int nv, output int ne);
    int v0;
    int e0;
    v0 = valid_seen;
    e0 = err_seen;
    host.xfer(n, w, hi, reply, oe_seen);
    repeat (8) @(negedge mclk);
    nv = valid_seen - v0;
    ne = err_seen - e0;
  endtask : run

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Clean frame: word in, reply out, line released
  task automatic sc_good;
    int nv;
    int ne;
    resp_src = '{status:8'h5A, rdata:16'hC3E1, info:7'h2B};
    run(32, 32'h96A5_1DB4, 2'b00, nv, ne);
    chk(nv == 1 && ne == 0, "clean frame not taken");
    chk(cmd === 32'h96A5_1DB4, "received word");
    chk(cmd.addr === 7'h34 && cmd.rw === 1'b1, "address field");
    chk(cmd.data === 16'hA51D, "data field");
    chk(reply === {8'h5A, 16'hC3E1, 7'h2B, 1'b0}, "reply");
    chk(oe_seen, "output never driven");
    chk(serial_out_oe === 1'b0, "output not released");
  endtask : sc_good

  // Short and long frames, each followed by a zero-clock probe
  task automatic sc_count;
    int nv;
    int ne;
    int lens[2] = '{31, 33};
    foreach (lens[k]) begin
      run(lens[k], 32'h0F0F_F0F0, 2'b00, nv, ne);
      chk(nv == 0 && ne == 1, "bad count accepted");
      chk(cmd === 32'h96A5_1DB4, "dropped word leaked");
      run(0, 32'h0000_0000, 2'b00, nv, ne);
      chk(reply[0] === 1'b1 && oe_seen, "error bit missing");
      chk(nv == 0 && ne == 0, "probe decoded");
    end
  endtask : sc_count

  // Clock high at either select edge, then flag shown once and consumed
  task automatic sc_edge;
    int nv;
    int ne;
    // 31 loop clocks plus the fall after select low: 32 counted clocks
    run(31, 32'h0000_1281, 2'b01, nv, ne);
    chk(nv == 0 && ne == 1, "clock at select fall");
    run(32, 32'h00BE_EF05, 2'b00, nv, ne);
    chk(reply[0] === 1'b1 && nv == 1, "error after edge");
    chk(cmd.data === 16'hBEEF && cmd.rw === 1'b0, "write word");
    run(32, 32'h0000_1281, 2'b10, nv, ne);
    chk(nv == 0 && ne == 1, "clock at select rise");
    chk(cmd.data === 16'hBEEF, "edge word leaked");
    run(32, 32'h0000_0006, 2'b00, nv, ne);
    chk(reply[0] === 1'b1 && nv == 1, "error after end edge");
    chk(cmd.addr === 7'h06, "address after error");
    run(32, 32'h0000_0007, 2'b00, nv, ne);
    chk(reply[0] === 1'b0 && nv == 1, "error not cleared");
  endtask : sc_edge

  // Mode drops mid-frame: drive stops at once, error owed on next reply
  task automatic sc_abort;
    int nv;
    int ne;
    fork
      run(32, 32'h0000_0081, 2'b00, nv, ne);
      begin
        repeat (100) @(negedge mclk);
        chk(serial_out_oe === 1'b1, "not driving mid-frame");
        mode = SPF_MODE_SLEEP;
        repeat (3) @(negedge mclk);
        chk(serial_out_oe === 1'b0, "drive kept after mode drop");
      end
    join
    chk(nv == 0 && ne == 0, "aborted frame decoded");
    mode = SPF_MODE_NORMAL;
    repeat (4) @(negedge mclk);
    run(32, 32'h0000_0082, 2'b00, nv, ne);
    chk(reply[0] === 1'b1 && nv == 1, "abort not flagged");
  endtask : sc_abort

  // Reset in mid-frame: port back to idle, next frame clean
  task automatic sc_reset;
    int nv;
    int ne;
    fork
      run(32, 32'h0000_0083, 2'b00, nv, ne);
      begin
        repeat (100) @(negedge mclk);
        rst = 1'b1;
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        chk(serial_out_oe === 1'b0 && cmd === 32'h0, "mid-run reset");
      end
    join
    chk(nv == 0 && ne == 0, "frame cut by reset decoded");
    run(32, 32'h0000_0084, 2'b00, nv, ne);
    chk(reply[0] === 1'b0 && nv == 1, "frame after reset");
    chk(cmd === 32'h0000_0084, "word after reset");
  endtask : sc_reset

  // Every mode: port works only in init, normal and stop
  task automatic sc_modes;
    int nv;
    int ne;
    for (int m = 0; m < 6; m++) begin
      mode = spf_mode_t'(m);
      repeat (4) @(negedge mclk);
      run(32, 32'h1234_0081 + m, 2'b00, nv, ne);
      chk(nv == int'(m < 3), "mode decode");
      chk(oe_seen == (m < 3), "mode drive");
      chk(ne == 0 && serial_out_oe === 1'b0, "mode idle");
    end
    mode = SPF_MODE_NORMAL;
  endtask : sc_modes

  // ----------------------------------------------------------------
  // Clock, main sequence, watchdog
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    rst      = 1'b1;
    mode     = SPF_MODE_NORMAL;
    resp_src = '0;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    repeat (6) @(negedge mclk);
    chk(serial_out_oe === 1'b0 && cmd === 32'h0, "reset state");
    sc_good();
    sc_count();
    sc_edge();
    sc_abort();
    sc_reset();
    sc_modes();
    close_out();
  end

  initial begin
    #500000;
    chk(1'b0, "run timed out");
    close_out();
  end

endmodule : spf_port_bench
